// file: pkg/dios_regs.svh
// Constants for the drive I/O supervisor
`ifndef DIOS_REGS_SVH
`define DIOS_REGS_SVH
`define DIOS_CLK_HZ 20000000
`define DIOS_MS_TICK_CYCLES (`DIOS_CLK_HZ / 1000)
`define DIOS_BRAKE_DELAY_MS 16'h00C8
`define DIOS_MAX_DECEL_RPSS 16'h0BB8
`define DIOS_TACH_BASE_PPR 16'h0064
`define DIOS_MS_W 16
`define DIOS_FAULT_W 8
`endif

// file: pkg/dios_pkg.sv
// Types for the drive I/O supervisor
package dios_pkg;
   typedef enum logic [1:0] {
      DIOS_FLT_CLOSE = 2'h0,
      DIOS_FLT_OPEN = 2'h1,
      DIOS_FLT_NEITHER = 2'h2
   } dios_fault_act_type;
   typedef enum logic [1:0] {
      DIOS_LIM_CLOSED = 2'h0,
      DIOS_LIM_OPEN = 2'h1,
      DIOS_LIM_UNUSED = 2'h2,
      DIOS_LIM_GPIN = 2'h3
   } dios_limit_type;
   typedef enum logic [1:0] {
      DIOS_MO_MOVE_CLOSED = 2'h0,
      DIOS_MO_MOVE_OPEN = 2'h1,
      DIOS_MO_TACH = 2'h2,
      DIOS_MO_UNUSED = 2'h3
   } dios_motion_type;
   typedef enum logic [1:0] {
      DIOS_EN_AUTO = 2'h0,
      DIOS_EN_CLOSED = 2'h1,
      DIOS_EN_OPEN = 2'h2
   } dios_enable_type;
   typedef enum logic [3:0] {
      DIOS_ST_OFF = 4'h1,
      DIOS_ST_RELEASE = 4'h2,
      DIOS_ST_RUN = 4'h4,
      DIOS_ST_ENGAGE = 4'h8
   } dios_state_type;
endpackage : dios_pkg

// file: core/dios_ms_timer.sv
// Millisecond tick divider and delay counter
`timescale 1ns/1ps
`include "dios_regs.svh"
module dios_ms_timer #(
   parameter int TICK_CYCLES = `DIOS_MS_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [`DIOS_MS_W-1:0] load_ms,
   output logic done
);
   localparam int DW = $clog2(TICK_CYCLES + 1);
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 1");
   end
   logic [DW-1:0] div_r;
   logic [DW-1:0] div_nxt;
   logic [`DIOS_MS_W-1:0] cnt_r;
   logic [`DIOS_MS_W-1:0] cnt_nxt;
   logic tick;
   // ****************
   // Divider and countdown
   // ****************
   always_comb begin
      tick = (div_r == DW'(TICK_CYCLES - 1));
      div_nxt = tick ? '0 : div_r + DW'(1);
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_ms;
         div_nxt = '0;
      end else if (tick && cnt_r != '0) begin
         cnt_nxt = cnt_r - `DIOS_MS_W'(1);
      end
      done = (cnt_r == '0) && !load;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r <= '0;
         cnt_r <= '0;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule : dios_ms_timer

// file: core/dios_supervisor.sv
// Drive I/O supervisor: fault, brake, limits, motion output, enable
`timescale 1ns/1ps
`include "dios_regs.svh"
module dios_supervisor #(
   parameter int TICK_CYCLES = `DIOS_MS_TICK_CYCLES,
   parameter int FAULT_W = `DIOS_FAULT_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [FAULT_W-1:0] fault_in,
   input wire logic [FAULT_W-1:0] fault_disable_mask,
   input wire dios_pkg::dios_fault_act_type fault_action,
   input wire logic alarm_clear_enable,
   input wire logic alarm_reset_drive,
   input wire logic alarm_clear_in,
   input wire logic brake_release_level,
   input wire logic [`DIOS_MS_W-1:0] release_delay_ms,
   input wire logic [`DIOS_MS_W-1:0] engage_delay_ms,
   input wire logic limit_pos_in,
   input wire logic limit_neg_in,
   input wire dios_pkg::dios_limit_type limit_mode,
   input wire logic [15:0] max_decel,
   input wire dios_pkg::dios_motion_type motion_mode,
   input wire logic motor_moving,
   input wire logic tach_step,
   input wire logic [2:0] tach_res_sel,
   input wire logic power_stage_enable_in,
   input wire dios_pkg::dios_enable_type enable_source,
   input wire logic host_enable_cmd,
   input wire logic host_disable_cmd,
   input wire logic [2:0] force_en,
   input wire logic [2:0] force_val,
   input wire logic move_req,
   output logic fault_indicate_out,
   output logic brake_control_out,
   output logic motion_indicate_out,
   output logic power_stage_on,
   output logic move_permit,
   output logic stop_req,
   output logic [15:0] stop_decel,
   output logic [1:0] gp_in,
   output logic led_red,
   output logic led_green
);
   if (FAULT_W < 1) begin : g_bad_width
      $error("FAULT_W must be at least 1");
   end
   // ****************
   // Input synchronisers
   // ****************
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {alarm_clear_in, limit_pos_in, limit_neg_in, power_stage_enable_in};
         sync2_r <= sync1_r;
      end
   end
   logic clr_s;
   logic limp_s;
   logic limn_s;
   logic en_s;
   assign {clr_s, limp_s, limn_s, en_s} = sync2_r;
   // ****************
   // Fault latch
   // ****************
   logic fault_act_r;
   logic fault_act_nxt;
   logic fault_lock_r;
   logic fault_lock_nxt;
   logic clr_prev_r;
   logic clr_rise;
   logic any_fault;
   logic dis_fault;
   always_comb begin
      any_fault = |fault_in;
      dis_fault = |(fault_in & fault_disable_mask);
      clr_rise = clr_s && !clr_prev_r;
      fault_act_nxt = fault_act_r;
      fault_lock_nxt = fault_lock_r;
      if (alarm_clear_enable && clr_rise) begin
         fault_act_nxt = 1'b0;
         if (alarm_reset_drive) begin
            fault_lock_nxt = 1'b0;
         end
      end
      // Set wins over a simultaneous clear
      if (any_fault) begin
         fault_act_nxt = 1'b1;
      end
      if (dis_fault) begin
         fault_lock_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_act_r <= 1'b0;
         fault_lock_r <= 1'b0;
         clr_prev_r <= 1'b0;
      end else begin
         fault_act_r <= fault_act_nxt;
         fault_lock_r <= fault_lock_nxt;
         clr_prev_r <= clr_s;
      end
   end
   // ****************
   // Limits
   // ****************
   logic [1:0] lim_hit;
   always_comb begin
      lim_hit = 2'h0;
      case (limit_mode)
         dios_pkg::DIOS_LIM_CLOSED: lim_hit = {limp_s, limn_s};
         dios_pkg::DIOS_LIM_OPEN: lim_hit = ~{limp_s, limn_s};
         default: lim_hit = 2'h0;
      endcase
   end
   // ****************
   // Enable and brake sequencer
   // ****************
   logic host_en_r;
   logic host_en_nxt;
   logic want_en;
   dios_pkg::dios_state_type st_r;
   dios_pkg::dios_state_type st_nxt;
   logic tmr_load;
   logic [`DIOS_MS_W-1:0] tmr_ms;
   logic tmr_done;
   always_comb begin
      host_en_nxt = host_en_r;
      if (host_disable_cmd) begin
         host_en_nxt = 1'b0;
      end else if (host_enable_cmd) begin
         host_en_nxt = 1'b1;
      end
      case (enable_source)
         dios_pkg::DIOS_EN_CLOSED: want_en = en_s;
         dios_pkg::DIOS_EN_OPEN: want_en = !en_s;
         default: want_en = 1'b1;
      endcase
      want_en = want_en && host_en_r && !fault_lock_r;
      st_nxt = st_r;
      tmr_load = 1'b0;
      tmr_ms = release_delay_ms;
      case (st_r)
         dios_pkg::DIOS_ST_OFF: begin
            if (want_en) begin
               st_nxt = dios_pkg::DIOS_ST_RELEASE;
               tmr_load = 1'b1;
            end
         end
         dios_pkg::DIOS_ST_RELEASE: begin
            if (!want_en) begin
               st_nxt = dios_pkg::DIOS_ST_ENGAGE;
               tmr_load = 1'b1;
               tmr_ms = engage_delay_ms;
            end else if (tmr_done) begin
               st_nxt = dios_pkg::DIOS_ST_RUN;
            end
         end
         dios_pkg::DIOS_ST_RUN: begin
            if (!want_en) begin
               st_nxt = dios_pkg::DIOS_ST_ENGAGE;
               tmr_load = 1'b1;
               tmr_ms = engage_delay_ms;
            end
         end
         dios_pkg::DIOS_ST_ENGAGE: begin
            if (tmr_done) begin
               st_nxt = dios_pkg::DIOS_ST_OFF;
            end
         end
         default: st_nxt = dios_pkg::DIOS_ST_OFF;
      endcase
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_en_r <= 1'b1;
         st_r <= dios_pkg::DIOS_ST_OFF;
      end else begin
         host_en_r <= host_en_nxt;
         st_r <= st_nxt;
      end
   end
   dios_ms_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .load_ms(tmr_ms),
      .done(tmr_done)
   );
   // ****************
   // Tachometer divider
   // ****************
   // tach_step pulses at 1600 per rev (or 16x electrical freq on other motors)
   logic [4:0] tach_cnt_r;
   logic [4:0] tach_cnt_nxt;
   logic tach_r;
   logic tach_nxt;
   logic [4:0] tach_half;
   always_comb begin
      // Half period in steps: 8 for 100 ppr down to 1 for 800 ppr
      case (tach_res_sel)
         3'h1: tach_half = 5'h4;
         3'h2: tach_half = 5'h2;
         3'h3: tach_half = 5'h1;
         default: tach_half = 5'h8;
      endcase
      tach_cnt_nxt = tach_cnt_r;
      tach_nxt = tach_r;
      if (tach_step) begin
         if (tach_cnt_r + 5'h1 >= tach_half) begin
            tach_cnt_nxt = 5'h0;
            tach_nxt = !tach_r;
         end else begin
            tach_cnt_nxt = tach_cnt_r + 5'h1;
         end
      end
   end
   // ****************
   // Status indicator blink
   // ****************
   logic [23:0] blink_r;
   logic [23:0] blink_nxt;
   // Starts in lit phase so a fault shows at once
   always_comb begin
      blink_nxt = blink_r + 24'h1;
   end
   // ****************
   // Output registers
   // ****************
   logic fault_out_nxt;
   logic brake_nxt;
   logic motion_nxt;
   logic pwr_nxt;
   always_comb begin
      case (fault_action)
         dios_pkg::DIOS_FLT_CLOSE: fault_out_nxt = fault_act_r;
         dios_pkg::DIOS_FLT_OPEN: fault_out_nxt = !fault_act_r;
         default: fault_out_nxt = 1'b0;
      endcase
      brake_nxt = (st_r == dios_pkg::DIOS_ST_RELEASE || st_r == dios_pkg::DIOS_ST_RUN)
         ? brake_release_level : !brake_release_level;
      case (motion_mode)
         dios_pkg::DIOS_MO_MOVE_CLOSED: motion_nxt = motor_moving;
         dios_pkg::DIOS_MO_MOVE_OPEN: motion_nxt = !motor_moving;
         // Sel 4: 1600 per rev passes step pulses through
         dios_pkg::DIOS_MO_TACH: motion_nxt = (tach_res_sel == 3'h4) ? tach_step : tach_r;
         default: motion_nxt = 1'b0;
      endcase
      if (force_en[0]) fault_out_nxt = force_val[0];
      if (force_en[1]) brake_nxt = force_val[1];
      if (force_en[2]) motion_nxt = force_val[2];
      pwr_nxt = (st_r != dios_pkg::DIOS_ST_OFF);
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tach_cnt_r <= 5'h0;
         tach_r <= 1'b0;
         blink_r <= 24'h800000;
         fault_indicate_out <= 1'b0;
         brake_control_out <= 1'b0;
         motion_indicate_out <= 1'b0;
         power_stage_on <= 1'b0;
         move_permit <= 1'b0;
         stop_req <= 1'b0;
         stop_decel <= `DIOS_MAX_DECEL_RPSS;
         gp_in <= 2'h0;
         led_red <= 1'b0;
         led_green <= 1'b0;
      end else begin
         tach_cnt_r <= tach_cnt_nxt;
         tach_r <= tach_nxt;
         blink_r <= blink_nxt;
         fault_indicate_out <= fault_out_nxt;
         brake_control_out <= brake_nxt;
         motion_indicate_out <= motion_nxt;
         power_stage_on <= pwr_nxt;
         move_permit <= move_req && st_r == dios_pkg::DIOS_ST_RUN && !(|lim_hit);
         stop_req <= (|lim_hit) || any_fault;
         stop_decel <= max_decel;
         gp_in <= (limit_mode == dios_pkg::DIOS_LIM_GPIN) ? {limp_s, limn_s} : 2'h0;
         led_red <= fault_act_r && blink_r[23];
         led_green <= fault_act_r ? (blink_r[23] && blink_r[21]) : 1'b1;
      end
   end
endmodule : dios_supervisor

// file: test/dios_supervisor_sva.sv
// Assertion checker for the drive I/O supervisor
`timescale 1ns/1ps
module dios_supervisor_sva #(
   parameter int FAULT_W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [FAULT_W-1:0] fault_in,
   input wire dios_pkg::dios_fault_act_type fault_action,
   input wire logic brake_release_level,
   input wire logic limit_pos_in,
   input wire dios_pkg::dios_limit_type limit_mode,
   input wire logic [15:0] max_decel,
   input wire dios_pkg::dios_motion_type motion_mode,
   input wire logic motor_moving,
   input wire logic [2:0] force_en,
   input wire logic move_req,
   input wire logic fault_indicate_out,
   input wire logic brake_control_out,
   input wire logic motion_indicate_out,
   input wire logic power_stage_on,
   input wire logic move_permit,
   input wire logic stop_req,
   input wire logic [15:0] stop_decel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   fault_close_a: assert property ((fault_in != '0 && force_en == 3'h0 &&
      fault_action == dios_pkg::DIOS_FLT_CLOSE) ##1 (force_en == 3'h0 &&
      fault_action == dios_pkg::DIOS_FLT_CLOSE) |-> ##1 fault_indicate_out)
      else $error("fault output not closed");
   fault_open_a: assert property ((fault_in != '0 && force_en == 3'h0 &&
      fault_action == dios_pkg::DIOS_FLT_OPEN) ##1 (force_en == 3'h0 &&
      fault_action == dios_pkg::DIOS_FLT_OPEN) |-> ##1 !fault_indicate_out)
      else $error("fault output not opened");
   permit_brake_a: assert property ((move_permit && force_en == 3'h0) |->
      (brake_control_out == brake_release_level && power_stage_on))
      else $error("move permitted with brake held");
   permit_req_a: assert property (move_permit |-> $past(move_req))
      else $error("move permitted without request");
   limit_block_a: assert property ((limit_mode == dios_pkg::DIOS_LIM_CLOSED
      && limit_pos_in) [*5] |-> !move_permit)
      else $error("move permitted at limit");
   limit_stop_a: assert property ((limit_mode == dios_pkg::DIOS_LIM_CLOSED
      && limit_pos_in) [*5] |-> stop_req)
      else $error("no stop request at limit");
   decel_copy_a: assert property (1'b1 |=> stop_decel == $past(max_decel))
      else $error("stop deceleration not copied");
   moving_ind_a: assert property ((motion_mode == dios_pkg::DIOS_MO_MOVE_CLOSED
      && motor_moving && force_en == 3'h0) [*4] |-> motion_indicate_out)
      else $error("motion output not closed");
   engage_first_a: assert property (($fell(power_stage_on) && force_en == 3'h0)
      |-> brake_control_out != brake_release_level)
      else $error("power off before brake engaged");
endmodule : dios_supervisor_sva
bind dios_supervisor dios_supervisor_sva #(.FAULT_W(FAULT_W)) u_sva (.clk, .sys_rst,
   .fault_in, .fault_action, .brake_release_level, .limit_pos_in, .limit_mode, .max_decel,
   .motion_mode, .motor_moving, .force_en, .move_req, .fault_indicate_out,
   .brake_control_out, .motion_indicate_out, .power_stage_on, .move_permit, .stop_req,
   .stop_decel);

// file: test/dios_machine_model.sv
// Machine-side motor model: motion feedback and tach steps
`timescale 1ns/1ps
module dios_machine_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic move_permit,
   output logic motor_moving,
   output logic tach_step
);
   logic step_nxt;
   always_comb begin
      step_nxt = move_permit & ~tach_step;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         motor_moving <= 1'b0;
         tach_step <= 1'b0;
      end else begin
         motor_moving <= move_permit;
         tach_step <= step_nxt;
      end
   end
endmodule : dios_machine_model

// file: test/drive_io_supervisor_test.sv
// Self-checking testbench for the drive I/O supervisor
`timescale 1ns/1ps
`include "dios_regs.svh"
module drive_io_supervisor_test;
   logic clk = 1'b0, sys_rst = 1'b1, brake_release_level = 1'b1, move_req = 1'b0;
   logic alarm_clear_enable = 1'b0, alarm_reset_drive = 1'b0, alarm_clear_in = 1'b0;
   logic limit_pos_in = 1'b0, limit_neg_in = 1'b0, power_stage_enable_in = 1'b0;
   logic host_enable_cmd = 1'b0, host_disable_cmd = 1'b0, motor_moving, tach_step, p;
   logic fault_indicate_out, brake_control_out, motion_indicate_out, power_stage_on;
   logic move_permit, stop_req, led_red, led_green;
   logic [1:0] gp_in;
   logic [7:0] fault_in = 8'h00, fault_disable_mask = 8'h01;
   logic [15:0] release_delay_ms = 16'h0003, engage_delay_ms = 16'h0003, stop_decel;
   logic [15:0] max_decel = 16'h0FA0;
   logic [2:0] tach_res_sel = 3'h0, force_en = 3'h0, force_val = 3'h0;
   dios_pkg::dios_fault_act_type fault_action = dios_pkg::DIOS_FLT_CLOSE;
   dios_pkg::dios_limit_type limit_mode = dios_pkg::DIOS_LIM_UNUSED;
   dios_pkg::dios_motion_type motion_mode = dios_pkg::DIOS_MO_MOVE_CLOSED;
   dios_pkg::dios_enable_type enable_source = dios_pkg::DIOS_EN_CLOSED;
   int err_total = 0, compares = 0, cyc, n;
   dios_supervisor #(.TICK_CYCLES(4)) u_dut (.clk, .sys_rst, .fault_in, .fault_disable_mask,
      .fault_action, .alarm_clear_enable, .alarm_reset_drive, .alarm_clear_in,
      .brake_release_level, .release_delay_ms, .engage_delay_ms, .limit_pos_in,
      .limit_neg_in, .limit_mode, .max_decel, .motion_mode, .motor_moving, .tach_step,
      .tach_res_sel, .power_stage_enable_in, .enable_source, .host_enable_cmd,
      .host_disable_cmd, .force_en, .force_val, .move_req, .fault_indicate_out,
      .brake_control_out, .motion_indicate_out, .power_stage_on, .move_permit, .stop_req,
      .stop_decel, .gp_in, .led_red, .led_green);
   dios_machine_model u_mach (.clk, .sys_rst, .move_permit, .motor_moving, .tach_step);
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      #2ms;
      err_total++;
      test_done;
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task wait_for(input int s, input logic v);
      cyc = 0;
      while ((s ? move_permit : power_stage_on) !== v && cyc < 300) begin
         step(1);
         cyc++;
      end
   endtask : wait_for
   task clear_pulse;
      @(posedge clk) alarm_clear_in <= 1'b1;
      step(4);
      @(posedge clk) alarm_clear_in <= 1'b0;
      step(4);
   endtask : clear_pulse
   task test_done;
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   // ********************
   // Stimulus
   // ********************
   initial begin
      step(1);
      chk(stop_decel, 16'h0BB8);
      @(posedge clk) sys_rst <= 1'b0;
      step(1);
      chk(brake_control_out, 1'b0);
      chk(led_green, 1'b1);
      chk(power_stage_on, 1'b0);
      chk(stop_decel, 16'h0FA0);
      @(posedge clk);
      power_stage_enable_in <= 1'b1;
      move_req <= 1'b1;
      wait_for(0, 1'b1);
      chk(cyc > 1 && cyc < 10, 1'b1);
      chk(brake_control_out, 1'b1);
      chk(move_permit, 1'b0);
      wait_for(1, 1'b1);
      chk(cyc > 6 && cyc < 17, 1'b1);
      step(6);
      chk(motion_indicate_out, 1'b1);
      @(posedge clk) motion_mode <= dios_pkg::DIOS_MO_MOVE_OPEN;
      step(4);
      chk(motion_indicate_out, 1'b0);
      @(posedge clk) motion_mode <= dios_pkg::DIOS_MO_TACH;
      for (int s = 0; s < 5; s++) begin
         @(posedge clk) tach_res_sel <= 3'(s);
         step(40);
         n = 0;
         for (int i = 0; i < 256; i++) begin
            p = motion_indicate_out;
            step(1);
            n += int'(motion_indicate_out != p);
         end
         chk(n >= (16 << s) - 1 && n <= (16 << s) + 1, 1'b1);
      end
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         limit_mode <= dios_pkg::dios_limit_type'(12'hE50 >> (2 * i));
         {limit_pos_in, limit_neg_in} <= 2'(12'hEE2 >> (2 * i));
         step(10);
         chk(move_permit, 1'(6'h3A >> i));
         chk(stop_req, 1'(6'h05 >> i));
      end
      chk(gp_in, 2'h3);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         fault_action <= dios_pkg::dios_fault_act_type'(i);
         fault_in <= 8'h02;
         step(3);
         chk(fault_indicate_out, i == 0);
      end
      chk(power_stage_on, 1'b1);
      chk(led_red, 1'b1);
      chk(led_green, 1'b0);
      @(posedge clk);
      fault_action <= dios_pkg::DIOS_FLT_CLOSE;
      fault_in <= 8'h00;
      clear_pulse;
      chk(fault_indicate_out, 1'b1);
      @(posedge clk) alarm_clear_enable <= 1'b1;
      clear_pulse;
      chk(fault_indicate_out, 1'b0);
      chk(led_red, 1'b0);
      @(posedge clk) fault_in <= 8'h01;
      step(2);
      @(posedge clk) fault_in <= 8'h00;
      wait_for(0, 1'b0);
      chk(cyc < 60, 1'b1);
      clear_pulse;
      chk(fault_indicate_out, 1'b0);
      step(20);
      chk(power_stage_on, 1'b0);
      @(posedge clk) alarm_reset_drive <= 1'b1;
      clear_pulse;
      wait_for(0, 1'b1);
      chk(cyc < 60, 1'b1);
      wait_for(1, 1'b1);
      chk(move_permit, 1'b1);
      @(posedge clk) power_stage_enable_in <= 1'b0;
      step(6);
      chk(brake_control_out, 1'b0);
      chk(power_stage_on, 1'b1);
      wait_for(0, 1'b0);
      chk(cyc > 1 && cyc < 15, 1'b1);
      @(posedge clk);
      force_en <= 3'h7;
      force_val <= 3'h5;
      step(3);
      chk({motion_indicate_out, brake_control_out, fault_indicate_out}, 3'h5);
      @(posedge clk);
      force_en <= 3'h0;
      motion_mode <= dios_pkg::DIOS_MO_UNUSED;
      enable_source <= dios_pkg::DIOS_EN_AUTO;
      wait_for(0, 1'b1);
      chk(cyc < 40, 1'b1);
      chk(motion_indicate_out, 1'b0);
      @(posedge clk) host_disable_cmd <= 1'b1;
      @(posedge clk) host_disable_cmd <= 1'b0;
      wait_for(0, 1'b0);
      chk(cyc < 40, 1'b1);
      @(posedge clk) host_enable_cmd <= 1'b1;
      @(posedge clk) host_enable_cmd <= 1'b0;
      wait_for(0, 1'b1);
      chk(cyc < 40, 1'b1);
      @(posedge clk) enable_source <= dios_pkg::DIOS_EN_OPEN;
      step(20);
      chk(power_stage_on, 1'b1);
      @(posedge clk) power_stage_enable_in <= 1'b1;
      wait_for(0, 1'b0);
      chk(cyc < 40, 1'b1);
      test_done;
   end
endmodule : drive_io_supervisor_test
